// ==== core/bbx_pkg.sv ====
// Package with the constants, opcodes and state layout of the branch and bit execution unit.
package bbx_pkg;

  // Bus and datapath widths.
  localparam int unsigned BBX_ADDR_W = 8;
  localparam int unsigned BBX_PC_W = 16;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] BBX_OFF_CTRL = 8'h00;
  localparam logic [7:0] BBX_OFF_PC = 8'h04;
  localparam logic [7:0] BBX_OFF_STATUS_REG = 8'h08;
  localparam logic [7:0] BBX_OFF_OPERAND = 8'h0c;
  localparam logic [7:0] BBX_OFF_IO = 8'h10;
  localparam logic [7:0] BBX_OFF_STATE = 8'h14;

  // Field positions of the control word.
  localparam int unsigned BBX_CTRL_OP_LSB = 0;
  localparam int unsigned BBX_CTRL_SEL_LSB = 8;
  localparam int unsigned BBX_CTRL_K_LSB = 16;
  localparam int unsigned BBX_CTRL_TWO_WORD_BIT = 24;

  // Field positions of the state word.
  localparam int unsigned BBX_ST_BUSY_BIT = 0;
  localparam int unsigned BBX_ST_TAKEN_BIT = 1;
  localparam int unsigned BBX_ST_ERR_BIT = 2;
  localparam int unsigned BBX_ST_CYC_LSB = 4;

  // Status register flag positions.
  localparam int unsigned BBX_FLAG_C = 0;
  localparam int unsigned BBX_FLAG_Z = 1;
  localparam int unsigned BBX_FLAG_N = 2;
  localparam int unsigned BBX_FLAG_V = 3;
  localparam int unsigned BBX_FLAG_S = 4;
  localparam int unsigned BBX_FLAG_H = 5;
  localparam int unsigned BBX_FLAG_T = 6;
  localparam int unsigned BBX_FLAG_I = 7;

  // Cycle counts of each kind of operation.
  localparam logic [1:0] BBX_CYC_NOT_TAKEN = 2'h1;
  localparam logic [1:0] BBX_CYC_TAKEN = 2'h2;
  localparam logic [1:0] BBX_CYC_SKIP_ONE = 2'h2;
  localparam logic [1:0] BBX_CYC_SKIP_TWO = 2'h3;
  localparam logic [1:0] BBX_CYC_IO_BIT = 2'h2;
  localparam logic [1:0] BBX_CYC_ALU = 2'h1;

  // AXI response codes.
  localparam logic [1:0] BBX_RESP_OKAY = 2'h0;
  localparam logic [1:0] BBX_RESP_SLVERR = 2'h2;

  // Operations; the position in this list is the opcode written to the control word.
  typedef enum logic [4:0] {
    op_skip_if_io_bit_set,
    op_branch_status_bit_set,
    op_branch_status_bit_clear,
    op_branch_equal,
    op_branch_not_equal,
    op_branch_carry_set,
    op_branch_lower,
    op_branch_carry_clear,
    op_branch_same_or_higher,
    op_branch_minus,
    op_branch_plus,
    op_branch_signed_ge,
    op_branch_signed_lt,
    op_branch_halfcarry_set,
    op_branch_halfcarry_clear,
    op_branch_tbit_set,
    op_branch_tbit_clear,
    op_branch_irq_enabled,
    op_branch_irq_disabled,
    op_io_bit_set,
    op_io_bit_clear,
    op_logical_shift_left,
    op_logical_shift_right,
    op_rotate_left_carry,
    op_rotate_right_carry,
    op_arith_shift_right,
    op_store_bit_to_tflag,
    op_load_bit_from_tflag
  } bbx_op_e;

  localparam logic [4:0] BBX_OP_LAST = 5'h1b;

  typedef enum logic {
    fsm_idle,
    fsm_exec
  } bbx_fsm_e;

  // The whole state of the unit.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_full;
    logic w_full;
    logic [BBX_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    bbx_fsm_e fsm;
    logic [1:0] cnt;
    bbx_op_e op;
    logic [2:0] sel;
    logic [6:0] k;
    logic two_word;
    logic [BBX_PC_W-1:0] pc;
    logic [7:0] status_register;
    logic [7:0] operand;
    logic [7:0] io;
    logic taken;
    logic err;
    logic [1:0] last_cyc;
  } bbx_state_s;

  localparam bbx_state_s BBX_STATE_RST = '0;

endpackage

// ==== core/bbx_exec.sv ====
// Branch, skip, I/O bit, shift and T-flag execution unit behind an AXI4-Lite slave.
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
module bbx_exec
  import bbx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [bbx_pkg::BBX_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [bbx_pkg::BBX_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic busy
);

  bbx_state_s s;
  bbx_state_s next_s;

  // Byte-lane merge of a bus write into a stored word.
  function automatic logic [31:0] merge_strb(logic [31:0] old, logic [31:0] data, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Branch test: returns {is_branch, condition_met}.
  function automatic logic [1:0] branch_test(bbx_op_e op, logic [7:0] sr, logic [2:0] sel);
    logic [1:0] r;
    r = 2'h0;
    unique case (op)
      op_branch_status_bit_set: r = {1'b1, sr[sel]};
      op_branch_status_bit_clear: r = {1'b1, ~sr[sel]};
      op_branch_equal: r = {1'b1, sr[BBX_FLAG_Z]};
      op_branch_not_equal: r = {1'b1, ~sr[BBX_FLAG_Z]};
      op_branch_carry_set, op_branch_lower: r = {1'b1, sr[BBX_FLAG_C]};
      op_branch_carry_clear, op_branch_same_or_higher: r = {1'b1, ~sr[BBX_FLAG_C]};
      op_branch_minus: r = {1'b1, sr[BBX_FLAG_N]};
      op_branch_plus: r = {1'b1, ~sr[BBX_FLAG_N]};
      op_branch_signed_ge: r = {1'b1, ~(sr[BBX_FLAG_N] ^ sr[BBX_FLAG_V])};
      op_branch_signed_lt: r = {1'b1, sr[BBX_FLAG_N] ^ sr[BBX_FLAG_V]};
      op_branch_halfcarry_set: r = {1'b1, sr[BBX_FLAG_H]};
      op_branch_halfcarry_clear: r = {1'b1, ~sr[BBX_FLAG_H]};
      op_branch_tbit_set: r = {1'b1, sr[BBX_FLAG_T]};
      op_branch_tbit_clear: r = {1'b1, ~sr[BBX_FLAG_T]};
      op_branch_irq_enabled: r = {1'b1, sr[BBX_FLAG_I]};
      op_branch_irq_disabled: r = {1'b1, ~sr[BBX_FLAG_I]};
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // Shift and rotate: returns {new operand, new status register}.
  function automatic logic [15:0] shift_op(bbx_op_e op, logic [7:0] d, logic [7:0] sr);
    logic [7:0] res;
    logic [7:0] f;
    logic c;
    res = d;
    f = sr;
    c = sr[BBX_FLAG_C];
    unique case (op)
      op_logical_shift_left:
      begin
        res = {d[6:0], 1'b0};
        c = d[7];
      end
      op_logical_shift_right:
      begin
        res = {1'b0, d[7:1]};
        c = d[0];
      end
      op_rotate_left_carry:
      begin
        res = {d[6:0], sr[BBX_FLAG_C]};
        c = d[7];
      end
      op_rotate_right_carry:
      begin
        res = {sr[BBX_FLAG_C], d[7:1]};
        c = d[0];
      end
      op_arith_shift_right:
      begin
        res = {d[7], d[7:1]};
        c = d[0];
      end
      default:
      begin
        res = d;
      end
    endcase
    // Only Z, C, N and V move; the signed-test flag is left alone on purpose.
    f[BBX_FLAG_C] = c;
    f[BBX_FLAG_Z] = (res == 8'h00);
    f[BBX_FLAG_N] = res[7];
    f[BBX_FLAG_V] = res[7] ^ c;
    return {res, f};
  endfunction

  // Number of cycles an operation occupies, known at issue time from the current state.
  function automatic logic [1:0] cycles_for(bbx_op_e op, logic [7:0] sr, logic [7:0] io,
                                           logic [2:0] sel, logic two);
    logic [1:0] bt;
    logic [1:0] r;
    bt = branch_test(op, sr, sel);
    r = BBX_CYC_ALU;
    if (bt[1])
    begin
      r = bt[0] ? BBX_CYC_TAKEN : BBX_CYC_NOT_TAKEN;
    end
    else if (op == op_skip_if_io_bit_set)
    begin
      if (io[sel])
      begin
        r = two ? BBX_CYC_SKIP_TWO : BBX_CYC_SKIP_ONE;
      end
      else
      begin
        r = BBX_CYC_NOT_TAKEN;
      end
    end
    else if (op == op_io_bit_set || op == op_io_bit_clear)
    begin
      r = BBX_CYC_IO_BIT;
    end
    return r;
  endfunction

  // Register read decode; the low bit says whether the address was mapped.
  function automatic logic [32:0] read_reg(bbx_state_s st, logic [BBX_ADDR_W-1:0] a);
    logic [31:0] d;
    logic ok;
    d = 32'h0;
    ok = 1'b1;
    unique case (a)
      BBX_OFF_CTRL:
      begin
        d[BBX_CTRL_OP_LSB +: 5] = st.op;
        d[BBX_CTRL_SEL_LSB +: 3] = st.sel;
        d[BBX_CTRL_K_LSB +: 7] = st.k;
        d[BBX_CTRL_TWO_WORD_BIT] = st.two_word;
      end
      BBX_OFF_PC: d[BBX_PC_W-1:0] = st.pc;
      BBX_OFF_STATUS_REG: d[7:0] = st.status_register;
      BBX_OFF_OPERAND: d[7:0] = st.operand;
      BBX_OFF_IO: d[7:0] = st.io;
      BBX_OFF_STATE:
      begin
        d[BBX_ST_BUSY_BIT] = (st.fsm == fsm_exec);
        d[BBX_ST_TAKEN_BIT] = st.taken;
        d[BBX_ST_ERR_BIT] = st.err;
        d[BBX_ST_CYC_LSB +: 2] = st.last_cyc;
      end
      default: ok = 1'b0;
    endcase
    return {d, ok};
  endfunction

  // Next state: execution, then the bus write channel, then the bus read channel.
  always_comb
  begin
    logic [1:0] bt;
    logic [15:0] sh;
    logic [31:0] wd;
    logic [31:0] mg;
    logic [32:0] rd;
    logic [BBX_PC_W-1:0] koff;
    bt = 2'h0;
    sh = 16'h0;
    wd = 32'h0;
    mg = 32'h0;
    rd = 33'h0;
    koff = '0;
    next_s = s;

    // Results land on the last cycle of an operation, so software sees one consistent update.
    if (s.fsm == fsm_exec)
    begin
      next_s.cnt = s.cnt - 2'h1;
      if (s.cnt == 2'h1)
      begin
        next_s.fsm = fsm_idle;
        bt = branch_test(s.op, s.status_register, s.sel);
        sh = shift_op(s.op, s.operand, s.status_register);
        koff = BBX_PC_W'(signed'(s.k));
        next_s.pc = s.pc + BBX_PC_W'(1);
        next_s.taken = 1'b0;
        if (bt[1] && bt[0])
        begin
          next_s.pc = s.pc + koff + BBX_PC_W'(1);
          next_s.taken = 1'b1;
        end
        unique case (s.op)
          op_skip_if_io_bit_set:
          begin
            if (s.io[s.sel])
            begin
              next_s.pc = s.pc + (s.two_word ? BBX_PC_W'(3) : BBX_PC_W'(2));
              next_s.taken = 1'b1;
            end
          end
          op_io_bit_set: next_s.io[s.sel] = 1'b1;
          op_io_bit_clear: next_s.io[s.sel] = 1'b0;
          op_logical_shift_left, op_logical_shift_right, op_rotate_left_carry,
          op_rotate_right_carry, op_arith_shift_right:
          begin
            next_s.operand = sh[15:8];
            next_s.status_register = sh[7:0];
          end
          op_store_bit_to_tflag: next_s.status_register[BBX_FLAG_T] = s.operand[s.sel];
          op_load_bit_from_tflag: next_s.operand[s.sel] = s.status_register[BBX_FLAG_T];
          default:
          begin
            next_s.fsm = fsm_idle;
          end
        endcase
      end
    end

    // Address and data are held separately so the master may offer them in either order.
    if (s.awready && awvalid)
    begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (s.wready && wvalid)
    begin
      next_s.w_full = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
    end

    // Writes are refused while an operation runs, so operands cannot change under it.
    if (s.aw_full && s.w_full && !s.bvalid)
    begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = BBX_RESP_OKAY;
      wd = s.w_data;
      if (s.fsm == fsm_exec)
      begin
        next_s.bresp = BBX_RESP_SLVERR;
      end
      else
      begin
        unique case (s.aw_addr)
          BBX_OFF_CTRL:
          begin
            rd = read_reg(s, BBX_OFF_CTRL);
            mg = merge_strb(rd[32:1], wd, s.w_strb);
            if (mg[BBX_CTRL_OP_LSB +: 5] > BBX_OP_LAST)
            begin
              next_s.bresp = BBX_RESP_SLVERR;
              next_s.err = 1'b1;
            end
            else
            begin
              next_s.op = bbx_op_e'(mg[BBX_CTRL_OP_LSB +: 5]);
              next_s.sel = mg[BBX_CTRL_SEL_LSB +: 3];
              next_s.k = mg[BBX_CTRL_K_LSB +: 7];
              next_s.two_word = mg[BBX_CTRL_TWO_WORD_BIT];
              next_s.err = 1'b0;
              next_s.fsm = fsm_exec;
              next_s.cnt = cycles_for(bbx_op_e'(mg[BBX_CTRL_OP_LSB +: 5]), s.status_register, s.io,
                                      mg[BBX_CTRL_SEL_LSB +: 3], mg[BBX_CTRL_TWO_WORD_BIT]);
              next_s.last_cyc = next_s.cnt;
            end
          end
          BBX_OFF_PC:
          begin
            mg = merge_strb({{(32-BBX_PC_W){1'b0}}, s.pc}, wd, s.w_strb);
            next_s.pc = mg[BBX_PC_W-1:0];
          end
          BBX_OFF_STATUS_REG:
          begin
            mg = merge_strb({24'h0, s.status_register}, wd, s.w_strb);
            next_s.status_register = mg[7:0];
          end
          BBX_OFF_OPERAND:
          begin
            mg = merge_strb({24'h0, s.operand}, wd, s.w_strb);
            next_s.operand = mg[7:0];
          end
          BBX_OFF_IO:
          begin
            mg = merge_strb({24'h0, s.io}, wd, s.w_strb);
            next_s.io = mg[7:0];
          end
          BBX_OFF_STATE:
          begin
            next_s.bresp = BBX_RESP_OKAY;
          end
          default: next_s.bresp = BBX_RESP_SLVERR;
        endcase
      end
    end
    next_s.awready = !next_s.aw_full;
    next_s.wready = !next_s.w_full;

    // One read at a time: the data word is captured when the address is taken.
    if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && arvalid)
    begin
      rd = read_reg(s, araddr);
      next_s.rvalid = 1'b1;
      next_s.rdata = rd[32:1];
      next_s.rresp = rd[0] ? BBX_RESP_OKAY : BBX_RESP_SLVERR;
    end
    next_s.arready = !next_s.rvalid;
  end

  // State register; every ready starts low and rises on the first edge after reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= BBX_STATE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state flops.
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign busy = (s.fsm == fsm_exec);

endmodule

// ==== testbench/bbx_exec_assertions.sv ====
// Concurrent checks on the bus ports and busy timing of the execution unit.
module bbx_exec_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] op_q;

  // Keep the opcode of the last data beat, since busy can only rise from a control write.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_q <= 5'h00;
    end
    else if (wvalid && wready)
    begin
      op_q <= wdata[4:0];
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_SKIP_CYC: assert property ($rose(busy) && op_q == 5'h00 |-> ##[1:3] !busy)
    else $error("skip busy longer than three cycles");
  AST_BRANCH_CYC: assert property ($rose(busy) && op_q inside {[5'h01:5'h12]} |=> ##[0:1] !busy)
    else $error("branch busy longer than two cycles");
  AST_IO_CYC: assert property ($rose(busy) && op_q inside {5'h13, 5'h14} |=> busy ##1 !busy)
    else $error("io bit operation not two cycles");
  AST_ALU_CYC: assert property ($rose(busy) && op_q inside {[5'h15:5'h1b]} |=> !busy)
    else $error("shift or bit copy not one cycle");
  AST_BUSY_START: assert property ($rose(busy) |-> $rose(bvalid))
    else $error("busy rose without a write response");
  AST_WRITE_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  AST_B_DROP: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  AST_R_DROP: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated");
endmodule

bind bbx_exec bbx_exec_assertions u_bbx_exec_assertions (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .busy(busy)
);

// ==== testbench/bbx_exec_tb_top.sv ====
// Self-checking bench for the branch and bit execution unit over its register bus.
module bbx_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bbx_pkg::*;

  localparam logic [1:0] ROK = BBX_RESP_OKAY;
  localparam logic [1:0] RER = BBX_RESP_SLVERR;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, busy;
  logic [BBX_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int bad_count = 0;
  int check_count = 0;
  logic [7:0] fl [3] = '{8'h00, 8'hff, 8'h5a};

  bbx_exec u_bbx_exec (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .busy(busy)
  );

  // Core clock at 200 MHz.
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compare one value and report a difference at once.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // A handshake that never came ends the run, as nothing after it can be trusted.
  task automatic hang(input logic ok);
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("mismatch handshake expected answer seen none");
      final_report();
    end
  endtask

  // One write: address and data offered together, each released at its own take.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid && n < 50);
    bready <= 1'b0;
    hang(bvalid);
    chk($sformatf("bresp@%h", a), {30'h0, er}, {30'h0, bresp});
  endtask

  // One read, with a mask so that only the bits of interest are compared.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                    input logic [31:0] m = 32'hffffffff);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid && n < 50);
    rready <= 1'b0;
    hang(rvalid);
    chk($sformatf("rresp@%h", a), {30'h0, er}, {30'h0, rresp});
    chk($sformatf("rdata@%h", a), exp, rdata & m);
  endtask

  // Issue one operation, wait for it to end, then check the state word.
  task automatic exe(input logic [31:0] c, input logic [31:0] st);
    int n;
    wr(BBX_OFF_CTRL, c, ROK);
    n = 0;
    while (busy !== 1'b0 && n < 50)
    begin
      @(posedge aclk);
      n++;
    end
    hang(!busy);
    rd(BBX_OFF_STATE, st, ROK);
  endtask

  function automatic logic [31:0] mk(input logic [4:0] o, input logic [2:0] s, input logic [6:0] k,
                                     input logic t);
    return {7'h00, t, 1'b0, k, 5'h00, s, 3'h0, o};
  endfunction

  function automatic logic cond(input logic [4:0] o, input logic [2:0] s, input logic [7:0] f);
    case (o)
      5'h01: return f[s];
      5'h02: return !f[s];
      5'h03: return f[1];
      5'h04: return !f[1];
      5'h05, 5'h06: return f[0];
      5'h07, 5'h08: return !f[0];
      5'h09: return f[2];
      5'h0a: return !f[2];
      5'h0b: return !(f[2] ^ f[3]);
      5'h0c: return f[2] ^ f[3];
      5'h0d: return f[5];
      5'h0e: return !f[5];
      5'h0f: return f[6];
      5'h10: return !f[6];
      5'h11: return f[7];
      default: return !f[7];
    endcase
  endfunction

  // Carry out on top, shifted byte below.
  function automatic logic [8:0] shf(input logic [4:0] o, input logic [7:0] d, input logic c);
    case (o)
      5'h15: return {d[7], d[6:0], 1'b0};
      5'h16: return {d[0], 1'b0, d[7:1]};
      5'h17: return {d[7], d[6:0], c};
      5'h18: return {d[0], c, d[7:1]};
      default: return {d[0], d[7], d[7:1]};
    endcase
  endfunction

  // Reset, then registers, branches, skips, io bits, shifts, bit copies and refusals.
  initial
  begin
    logic [7:0] f;
    logic [6:0] k;
    logic [8:0] r;
    logic [1:0] d;
    logic t;
    aresetn = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 24; a += 4)
      rd(a[7:0], 32'h0, ROK);
    rd(8'h18, 32'h0, RER);
    wr(8'h18, 32'hffffffff, RER);
    for (int v = 0; v < 3; v++)
      for (int o = 1; o < 19; o++)
      begin
        f = fl[v];
        k = o[0] ? 7'h7e : 7'h05;
        t = cond(o[4:0], o[2:0], f);
        wr(BBX_OFF_STATUS_REG, {24'h0, f}, ROK);
        wr(BBX_OFF_PC, 32'h100, ROK);
        exe(mk(o[4:0], o[2:0], k, 1'b0), {26'h0, t ? 2'h2 : 2'h1, 2'h0, t, 1'b0});
        rd(BBX_OFF_PC, t ? 32'h101 + {{25{k[6]}}, k} : 32'h101, ROK);
        rd(BBX_OFF_STATUS_REG, {24'h0, f}, ROK);
      end
    wr(BBX_OFF_IO, 32'h10, ROK);
    for (int i = 0; i < 3; i++)
    begin
      d = (i == 0) ? 2'h2 : (i == 1) ? 2'h3 : 2'h1;
      wr(BBX_OFF_PC, 32'h200, ROK);
      exe(mk(5'h00, i == 2 ? 3'h3 : 3'h4, 7'h00, i == 1), {26'h0, d, 2'h0, i < 2, 1'b0});
      rd(BBX_OFF_PC, 32'h200 + d, ROK);
    end
    wr(BBX_OFF_STATUS_REG, 32'ha5, ROK);
    wr(BBX_OFF_IO, 32'h5a, ROK);
    exe(mk(5'h13, 3'h0, 7'h00, 1'b0), 32'h20);
    rd(BBX_OFF_IO, 32'h5b, ROK);
    exe(mk(5'h14, 3'h6, 7'h00, 1'b0), 32'h20);
    rd(BBX_OFF_IO, 32'h1b, ROK);
    rd(BBX_OFF_STATUS_REG, 32'ha5, ROK);
    for (int o = 21; o < 26; o++)
      for (int c = 0; c < 2; c++)
      begin
        r = shf(o[4:0], c ? 8'h81 : 8'h80, c[0]);
        f = c ? 8'hf1 : 8'hfe;
        wr(BBX_OFF_STATUS_REG, {24'h0, f}, ROK);
        wr(BBX_OFF_OPERAND, c ? 32'h81 : 32'h80, ROK);
        exe(mk(o[4:0], 3'h0, 7'h00, 1'b0), 32'h10);
        rd(BBX_OFF_OPERAND, {24'h0, r[7:0]}, ROK);
        rd(BBX_OFF_STATUS_REG, {24'h0, f[7:4], r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]}, ROK);
      end
    wr(BBX_OFF_STATUS_REG, 32'h00, ROK);
    wr(BBX_OFF_OPERAND, 32'h08, ROK);
    exe(mk(5'h1a, 3'h3, 7'h00, 1'b0), 32'h10);
    rd(BBX_OFF_STATUS_REG, 32'h40, ROK);
    wr(BBX_OFF_OPERAND, 32'h00, ROK);
    exe(mk(5'h1b, 3'h5, 7'h00, 1'b0), 32'h10);
    rd(BBX_OFF_OPERAND, 32'h20, ROK);
    rd(BBX_OFF_STATUS_REG, 32'h40, ROK);
    // Only byte lane 1 of the PC may change under a partial strobe.
    wr(BBX_OFF_PC, 32'h00ff, ROK);
    wstrb <= 4'h2;
    wr(BBX_OFF_PC, 32'h1234, ROK);
    wstrb <= 4'hf;
    rd(BBX_OFF_PC, 32'h12ff, ROK);
    wr(BBX_OFF_CTRL, mk(5'h1c, 3'h0, 7'h00, 1'b0), RER);
    rd(BBX_OFF_STATE, 32'h4, ROK, 32'h7);
    wr(BBX_OFF_STATE, 32'h0, ROK);
    rd(BBX_OFF_STATE, 32'h4, ROK, 32'h7);
    final_report();
  end
endmodule
